// ==== shared/srfl_pkg.sv ====
// Shared constants, state type and divider arithmetic for the serial unit.
// Assumes a single bus clock domain; imported by every core module.
package srfl_pkg;
	localparam int unsigned SRFL_DW = 8;
	localparam int unsigned SRFL_CW = 12;
	localparam logic [7:0] SRFL_DATA_RST = 8'h00;
	// Pin idle levels {data in, data out, select, clock}: clock low, the rest high
	localparam logic [3:0] SRFL_SYNC_RST = 4'hE;
	localparam logic [3:0] SRFL_RATE_MAX = 4'h8;
	localparam logic [11:0] SRFL_ONE = 12'h001;
	localparam logic [3:0] SRFL_LAST_EDGE = 4'hF;
	localparam int unsigned SRFL_PIN_SCK = 0;
	localparam int unsigned SRFL_PIN_SS = 1;
	localparam int unsigned SRFL_PIN_MOSI = 2;
	localparam int unsigned SRFL_PIN_MISO = 3;
	localparam int unsigned SRFL_MSB = 7;

	typedef enum logic [0:0] {SRFL_IDLE, SRFL_XFER} srfl_state_t;

	// Half a bit period in bus clocks: (prescale + 1) * 2^rate_sel, with rate_sel capped at 8
	function automatic logic [11:0] srfl_half_div(input logic [2:0] ps, input logic [3:0] rs);
		logic [3:0] r;
		r = (rs > SRFL_RATE_MAX) ? SRFL_RATE_MAX : rs;
		return ({9'h000, ps} + SRFL_ONE) << r;
	endfunction
endpackage

// ==== shared/srfl_core_if.sv ====
// Internal carrier between the main core, its rate divider and pin synchroniser.
// Assumes one clock; all members are plain levels or one-cycle pulses.
`timescale 1ns/1ns
interface srfl_core_if;
	logic clk_en;
	logic run;
	logic [2:0] prescale_sel;
	logic [3:0] rate_sel;
	logic tick;
	logic [3:0] raw;
	logic [3:0] clean;
	modport core (output clk_en, run, prescale_sel, rate_sel, raw, input tick, clean);
	modport baud (input clk_en, run, prescale_sel, rate_sel, output tick);
	modport sync (input clk_en, raw, output clean);
endinterface

// ==== core/srfl_baud.sv ====
// Bit-rate divider: one tick per half bit period while run is high.
// Assumes run drops whenever no master transfer is moving.
`timescale 1ns/1ns
module srfl_baud import srfl_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_n,
	srfl_core_if.baud bus
);
	logic [SRFL_CW-1:0] cnt_q;
	logic tick_q;
	logic [SRFL_CW-1:0] half;

	assign half = srfl_half_div(bus.prescale_sel, bus.rate_sel);
	assign bus.tick = tick_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (bus.clk_en) begin
			if (!bus.run) begin
				cnt_q <= '0;
				tick_q <= 1'b0;
			end else if (cnt_q >= half - SRFL_ONE) begin
				cnt_q <= '0;
				tick_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + SRFL_ONE;
				tick_q <= 1'b0;
			end
		end
	end

	halt_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		bus.clk_en && !bus.run |=> !tick_q) else $error("divider ticked while stopped");
endmodule

// ==== core/srfl_sync.sv ====
// Three-stage synchroniser for the four serial pins.
// A new level is taken only once stages two and three agree.
`timescale 1ns/1ns
module srfl_sync import srfl_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_n,
	srfl_core_if.sync bus
);
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] clean_q;

	assign bus.clean = clean_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= SRFL_SYNC_RST;
			s2_q <= SRFL_SYNC_RST;
			s3_q <= SRFL_SYNC_RST;
			clean_q <= SRFL_SYNC_RST;
		end else if (bus.clk_en) begin
			s1_q <= bus.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < 4; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					clean_q[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// ==== core/srfl_top.sv ====
// Serial unit core: rate divider control, auto select, single-wire pins,
// mode fault, low-power behaviour. Control bits arrive as plain levels.
// Assumes software strobes are one-cycle pulses on the bus clock.
`timescale 1ns/1ns
module srfl_top import srfl_pkg::*; (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_CLK_EN,
	input wire logic I_SYSTEM_ENABLE,
	input wire logic I_MASTER_SEL,
	input wire logic I_SEL_OUT_EN,
	input wire logic I_FAULT_DETECT_EN,
	input wire logic I_SINGLE_WIRE_SEL,
	input wire logic I_SHARED_PIN_OUT_EN,
	input wire logic I_STOP_IN_WAIT,
	input wire logic I_RX_FAULT_IRQ_EN,
	input wire logic [2:0] I_PRESCALE_SEL,
	input wire logic [3:0] I_RATE_SEL,
	input wire logic I_WAIT_MODE,
	input wire logic I_STOP_MODE,
	input wire logic I_DEEP_STOP,
	input wire logic I_DATA_WR,
	input wire logic [7:0] I_DATA_WDATA,
	input wire logic I_DATA_RD,
	input wire logic I_STATUS_RD,
	input wire logic I_CTRL1_WR,
	input wire logic I_SCK,
	input wire logic I_SS_N,
	input wire logic I_MOSI,
	input wire logic I_MISO,
	output logic O_SCK,
	output logic O_SCK_OE,
	output logic O_SS_N,
	output logic O_SS_OE,
	output logic O_MOSI,
	output logic O_MOSI_OE,
	output logic O_MISO,
	output logic O_MISO_OE,
	output logic [7:0] O_DATA_REG,
	output logic O_RX_FULL_FLAG,
	output logic O_FAULT_FLAG,
	output logic O_MASTER_ACTIVE,
	output logic O_BUSY,
	output logic O_IRQ
);
	srfl_core_if cif ();

	srfl_state_t state_q;
	logic [3:0] edge_q;
	logic [7:0] shift_q;
	logic sample_q;
	logic sck_q;
	logic sck_p_q;
	logic [7:0] data_q;
	logic rx_full_q;
	logic pend_q;
	logic [7:0] pend_data_q;
	logic fault_q;
	logic armed_q;
	logic oe_block_q;
	logic o_sck_oe_q, o_ss_n_q, o_ss_oe_q, o_mosi_q, o_mosi_oe_q;
	logic o_miso_q, o_miso_oe_q, o_mst_q, o_busy_q, o_irq_q;

	logic sck_s, ss_n_s, mosi_s, miso_s;
	logic eff_master, auto_ss, detect, fault_set, lowp, busy;
	logic rise, fall, din, oe_ok, abort, done, mtick;
	logic [7:0] rx_byte;

	assign cif.clk_en = I_CLK_EN;
	assign cif.prescale_sel = I_PRESCALE_SEL;
	assign cif.rate_sel = I_RATE_SEL;
	assign cif.raw = {I_MISO, I_MOSI, I_SS_N, I_SCK};
	assign sck_s = cif.clean[SRFL_PIN_SCK];
	assign ss_n_s = cif.clean[SRFL_PIN_SS];
	assign mosi_s = cif.clean[SRFL_PIN_MOSI];
	assign miso_s = cif.clean[SRFL_PIN_MISO];

	srfl_baud u_baud (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.bus(cif.baud)
	);

	srfl_sync u_sync (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.bus(cif.sync)
	);

	assign eff_master = I_MASTER_SEL && !fault_q;
	assign auto_ss = eff_master && I_SEL_OUT_EN && I_FAULT_DETECT_EN;
	assign detect = eff_master && I_FAULT_DETECT_EN && !I_SEL_OUT_EN && I_SYSTEM_ENABLE;
	assign fault_set = detect && !ss_n_s;
	assign lowp = I_STOP_MODE || (I_WAIT_MODE && I_STOP_IN_WAIT);
	assign busy = (state_q == SRFL_XFER);
	// divider runs for an unpaused master transfer
	assign cif.run = eff_master && busy && !lowp && I_SYSTEM_ENABLE;
	// a tick already issued must not land once the pause starts
	assign mtick = cif.tick && cif.run;
	// slave edges follow the external clock regardless of low power
	assign rise = eff_master ? (mtick && !edge_q[0]) : (sck_s && !sck_p_q);
	assign fall = eff_master ? (mtick && edge_q[0]) : (!sck_s && sck_p_q);
	// Limitation: pin synchroniser needs master half periods of five clocks or more
	// shared pin also feeds the shifter
	assign din = eff_master ? (I_SINGLE_WIRE_SEL ? mosi_s : miso_s) : (I_SINGLE_WIRE_SEL ? miso_s : mosi_s);
	// blocked out-enable after a single-wire fault
	assign oe_ok = I_SHARED_PIN_OUT_EN && !oe_block_q;
	assign abort = fault_set || fault_q || !I_SYSTEM_ENABLE || (!eff_master && ss_n_s);
	assign done = busy && !abort && fall && (edge_q == SRFL_LAST_EDGE);
	assign rx_byte = {shift_q[SRFL_MSB-1:0], sample_q};

	// Transfer sequencing and shifter
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q <= SRFL_IDLE;
			edge_q <= '0;
			shift_q <= SRFL_DATA_RST;
			sample_q <= 1'b0;
			sck_q <= 1'b0;
			sck_p_q <= SRFL_SYNC_RST[SRFL_PIN_SCK];
		end else if (I_DEEP_STOP) begin
			state_q <= SRFL_IDLE;
			edge_q <= '0;
			shift_q <= SRFL_DATA_RST;
			sample_q <= 1'b0;
			sck_q <= 1'b0;
			sck_p_q <= sck_s;
		end else if (I_CLK_EN) begin
			sck_p_q <= sck_s;
			if (abort) begin
				state_q <= SRFL_IDLE;
				edge_q <= '0;
				sck_q <= 1'b0;
				if (I_DATA_WR && !eff_master) begin
					shift_q <= I_DATA_WDATA;
				end
			end else if (!busy) begin
				sck_q <= 1'b0;
				if (I_DATA_WR) begin
					shift_q <= I_DATA_WDATA;
				end
				// Master starts on a data write, slave when selected
				if (!eff_master || I_DATA_WR) begin
					state_q <= SRFL_XFER;
					edge_q <= '0;
				end
			end else begin
				if (rise || fall) begin
					edge_q <= edge_q + 4'h1;
				end
				if (eff_master && mtick) begin
					sck_q <= !sck_q;
				end
				if (rise) begin
					sample_q <= din;
				end
				// slave keeps resending its current contents
				if (fall) begin
					shift_q <= rx_byte;
				end
				if (done && eff_master) begin
					state_q <= SRFL_IDLE;
				end
			end
		end
	end

	// Received data, receive flag, deferred delivery
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			data_q <= SRFL_DATA_RST;
			rx_full_q <= 1'b0;
			pend_q <= 1'b0;
			pend_data_q <= SRFL_DATA_RST;
		end else if (I_DEEP_STOP) begin
			data_q <= SRFL_DATA_RST;
			rx_full_q <= 1'b0;
			pend_q <= 1'b0;
			pend_data_q <= SRFL_DATA_RST;
		end else if (I_CLK_EN) begin
			if (I_DATA_RD) begin
				rx_full_q <= 1'b0;
			end
			// slave in low power holds the byte until exit
			if (done && lowp && !eff_master) begin
				pend_q <= 1'b1;
				pend_data_q <= rx_byte;
			end else if (pend_q && !lowp) begin
				pend_q <= 1'b0;
				if (!rx_full_q || I_DATA_RD) begin
					data_q <= pend_data_q;
				end
				rx_full_q <= 1'b1;
			end else if (done) begin
				// Unserviced byte is dropped, flag set still wins over read
				if (!rx_full_q || I_DATA_RD) begin
					data_q <= rx_byte;
				end
				rx_full_q <= 1'b1;
			end
		end
	end

	// Mode fault flag and its two-step clear
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			fault_q <= 1'b0;
			armed_q <= 1'b0;
			oe_block_q <= 1'b0;
		end else if (I_DEEP_STOP) begin
			fault_q <= 1'b0;
			armed_q <= 1'b0;
			oe_block_q <= 1'b0;
		end else if (I_CLK_EN) begin
			// read with flag set arms, control write clears; a new fault wins
			if (fault_set) begin
				fault_q <= 1'b1;
			end else if (armed_q && I_CTRL1_WR) begin
				fault_q <= 1'b0;
			end
			if (I_CTRL1_WR || !fault_q) begin
				armed_q <= 1'b0;
			end else if (I_STATUS_RD) begin
				armed_q <= 1'b1;
			end
			// stays blocked until software drops the enable
			if (fault_set && I_SINGLE_WIRE_SEL) begin
				oe_block_q <= 1'b1;
			end else if (!I_SHARED_PIN_OUT_EN) begin
				oe_block_q <= 1'b0;
			end
		end
	end

	// Registered pin drivers and status outputs
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			o_sck_oe_q <= 1'b0;
			o_ss_n_q <= 1'b1;
			o_ss_oe_q <= 1'b0;
			o_mosi_q <= 1'b0;
			o_mosi_oe_q <= 1'b0;
			o_miso_q <= 1'b0;
			o_miso_oe_q <= 1'b0;
			o_mst_q <= 1'b0;
			o_busy_q <= 1'b0;
			o_irq_q <= 1'b0;
		end else if (I_DEEP_STOP) begin
			o_sck_oe_q <= 1'b0;
			o_ss_n_q <= 1'b1;
			o_ss_oe_q <= 1'b0;
			o_mosi_q <= 1'b0;
			o_mosi_oe_q <= 1'b0;
			o_miso_q <= 1'b0;
			o_miso_oe_q <= 1'b0;
			o_mst_q <= 1'b0;
			o_busy_q <= 1'b0;
			o_irq_q <= 1'b0;
		end else if (I_CLK_EN) begin
			// clock driven only by an active master
			o_sck_oe_q <= eff_master && I_SYSTEM_ENABLE;
			o_ss_n_q <= !busy;
			o_ss_oe_q <= auto_ss && I_SYSTEM_ENABLE;
			o_mosi_q <= shift_q[SRFL_MSB];
			o_miso_q <= shift_q[SRFL_MSB];
			o_mosi_oe_q <= I_SYSTEM_ENABLE && eff_master && (!I_SINGLE_WIRE_SEL || oe_ok);
			o_miso_oe_q <= I_SYSTEM_ENABLE && !I_MASTER_SEL && !fault_q && !ss_n_s
				&& (!I_SINGLE_WIRE_SEL || oe_ok);
			o_mst_q <= eff_master;
			o_busy_q <= busy;
			o_irq_q <= I_SYSTEM_ENABLE && I_RX_FAULT_IRQ_EN && (rx_full_q || fault_q);
		end
	end

	assign O_SCK = sck_q;
	assign O_SCK_OE = o_sck_oe_q;
	assign O_SS_N = o_ss_n_q;
	assign O_SS_OE = o_ss_oe_q;
	assign O_MOSI = o_mosi_q;
	assign O_MOSI_OE = o_mosi_oe_q;
	assign O_MISO = o_miso_q;
	assign O_MISO_OE = o_miso_oe_q;
	assign O_DATA_REG = data_q;
	assign O_RX_FULL_FLAG = rx_full_q;
	assign O_FAULT_FLAG = fault_q;
	assign O_MASTER_ACTIVE = o_mst_q;
	assign O_BUSY = o_busy_q;
	assign O_IRQ = o_irq_q;

	default clocking dc @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N || I_DEEP_STOP);

	sequence fault_armed_s;
		I_CLK_EN && armed_q && fault_q;
	endsequence
	sequence clear_write_s;
		I_CTRL1_WR && !fault_set;
	endsequence

	fault_set_a: assert property (I_CLK_EN && fault_set |=> fault_q) else $error("fault not raised");
	fault_quiet_a: assert property (I_CLK_EN && !fault_q && (!I_MASTER_SEL || !I_FAULT_DETECT_EN)
		|=> !fault_q) else $error("fault raised without detection");
	fault_drivers_a: assert property (I_CLK_EN && fault_q |=> !O_SCK_OE && !O_MOSI_OE && !O_MISO_OE)
		else $error("driver on during fault");
	auto_select_a: assert property (I_CLK_EN && I_SYSTEM_ENABLE && auto_ss |=> O_SS_OE && (O_SS_N == !$past(busy)))
		else $error("auto select wrong");
	fault_clear_a: assert property (fault_armed_s ##0 clear_write_s |=> !fault_q)
		else $error("fault not cleared");
	slave_defer_a: assert property (I_CLK_EN && lowp && !eff_master |=> !$rose(rx_full_q))
		else $error("receive flag during low power");
	irq_gate_a: assert property (I_CLK_EN && !I_SYSTEM_ENABLE |=> !O_IRQ)
		else $error("interrupt while disabled");
	master_pause_a: assert property (I_CLK_EN && busy && eff_master && lowp && !abort |=> $stable(sck_q))
		else $error("master clock moved while paused");
endmodule

// ==== verification/srfl_peer.sv ====
// Far-side serial slave: mode 0, MSB first, one byte per selection.
// Assumes the bench resolves clock and select lines; data line released when deselected.
`timescale 1ns/1ns
module srfl_peer (
	input wire logic i_sck,
	input wire logic i_ss_n,
	input wire logic i_mosi,
	input wire logic [7:0] i_tx,
	output logic o_miso,
	output logic o_miso_oe,
	output logic [7:0] o_rx
);
	logic [7:0] tx_q;
	initial begin
		tx_q = 8'h00;
		o_rx = 8'h00;
	end
	// Byte is taken only at selection, so a late change of i_tx is not seen
	always @(negedge i_ss_n) begin
		tx_q = i_tx;
	end
	always @(posedge i_sck) begin
		if (!i_ss_n) begin
			o_rx = {o_rx[6:0], i_mosi};
		end
	end
	always @(negedge i_sck) begin
		if (!i_ss_n) begin
			tx_q = {tx_q[6:0], 1'b0};
		end
	end
	assign o_miso_oe = !i_ss_n;
	assign o_miso = tx_q[7];
endmodule

// ==== verification/srfl_top_test.sv ====
// Self-checking bench for the serial unit: rates, auto select, faults, low power.
// Assumes pull-ups on select and data lines and a pull-down on the clock line.
`timescale 1ns/1ns
module srfl_top_test;
	import srfl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sys_en, mst, soe, fden, swire, shoe, siw, irqen, wt, stp, dstop, dwr, drd, srd, cwr, ss_pull;
	logic [2:0] prs;
	logic [3:0] rte;
	logic [7:0] wdata, ptx, prx, dreg;
	logic o_sck, o_sck_oe, o_ss_n, o_ss_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
	logic busy, rxf, flt, mact, irq, p_miso, p_oe, sck_w, ss_w, mosi_w, miso_w, sck_p;
	logic bsck = 1'b0;
	logic bmosi = 1'b1;
	int cyc = 0;
	int cnt = 0;
	int per = 0;
	int n_rise = 0;
	int n_errors = 0;
	int n_tests = 0;
	assign sck_w = o_sck_oe ? o_sck : bsck;
	assign ss_w = o_ss_oe ? o_ss_n : !ss_pull;
	assign mosi_w = o_mosi_oe ? o_mosi : bmosi;
	assign miso_w = o_miso_oe ? o_miso : (p_oe ? p_miso : 1'b1);
	srfl_top srfl_top_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CLK_EN(1'b1), .I_SYSTEM_ENABLE(sys_en),
		.I_MASTER_SEL(mst), .I_SEL_OUT_EN(soe), .I_FAULT_DETECT_EN(fden), .I_SINGLE_WIRE_SEL(swire),
		.I_SHARED_PIN_OUT_EN(shoe), .I_STOP_IN_WAIT(siw), .I_RX_FAULT_IRQ_EN(irqen), .I_PRESCALE_SEL(prs),
		.I_RATE_SEL(rte), .I_WAIT_MODE(wt), .I_STOP_MODE(stp), .I_DEEP_STOP(dstop), .I_DATA_WR(dwr),
		.I_DATA_WDATA(wdata), .I_DATA_RD(drd), .I_STATUS_RD(srd), .I_CTRL1_WR(cwr), .I_SCK(sck_w),
		.I_SS_N(ss_w), .I_MOSI(mosi_w), .I_MISO(miso_w), .O_SCK(o_sck), .O_SCK_OE(o_sck_oe),
		.O_SS_N(o_ss_n), .O_SS_OE(o_ss_oe), .O_MOSI(o_mosi), .O_MOSI_OE(o_mosi_oe), .O_MISO(o_miso),
		.O_MISO_OE(o_miso_oe), .O_DATA_REG(dreg), .O_RX_FULL_FLAG(rxf), .O_FAULT_FLAG(flt),
		.O_MASTER_ACTIVE(mact), .O_BUSY(busy), .O_IRQ(irq));
	srfl_peer srfl_peer_i (.i_sck(sck_w), .i_ss_n(ss_w), .i_mosi(mosi_w), .i_tx(ptx), .o_miso(p_miso),
		.o_miso_oe(p_oe), .o_rx(prx));
	initial begin
		forever #2 clk = ~clk;
	end
	// Interval between clock-pin rises gives the full bit period
	always @(posedge clk) begin
		cyc++;
		cnt++;
		if (o_sck === 1'b1 && sck_p === 1'b0) begin
			per = cnt;
			cnt = 0;
			n_rise++;
		end
		sck_p = o_sck;
		if (cyc == 30000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic strobe(input int k);
		@(negedge clk);
		{cwr, srd, drd, dwr} = 4'h1 << k;
		@(negedge clk);
		{cwr, srd, drd, dwr} = 4'h0;
	endtask
	task automatic wait_for(input logic v, input int lim);
		int i;
		i = 0;
		while (busy !== v && i < lim) begin
			@(negedge clk);
			i++;
		end
		check("busy", {15'h0000, busy}, {15'h0000, v});
	endtask
	task automatic xfer(input logic [2:0] ps, input logic [3:0] rs, input logic [7:0] tx, input logic [7:0] rx,
		input int pz);
		int r0;
		int dv;
		dv = (ps + 1) * (2 << ((rs > 8) ? 8 : rs));
		@(negedge clk);
		{mst, soe, fden, swire} = 4'hE;
		prs = ps;
		rte = rs;
		ptx = rx;
		wdata = tx;
		strobe(0);
		wait_for(1'b1, 10);
		tick(6);
		check("ss low", {15'h0000, o_ss_n}, 16'h0000);
		check("sck out", {15'h0000, o_sck_oe}, 16'h0001);
		check("ss out", {15'h0000, o_ss_oe}, 16'h0001);
		if (pz != 0) begin
			wt = (pz == 1);
			siw = (pz == 1);
			stp = (pz == 2);
			tick(4);
			r0 = n_rise;
			tick(40);
			check("paused", 16'(n_rise - r0), 16'h0000);
			{wt, siw, stp} = 3'h0;
		end
		wait_for(1'b0, 9000);
		tick(3);
		check("no fault", {15'h0000, flt}, 16'h0000);
		check("period", 16'(per), 16'(dv));
		check("master rx", {8'h00, dreg}, {8'h00, rx});
		check("peer rx", {8'h00, prx}, {8'h00, tx});
		check("rx flag", {15'h0000, rxf}, 16'h0001);
		check("ss idle", {15'h0000, o_ss_n}, 16'h0001);
	endtask
	task automatic t_disable();
		int r0;
		@(negedge clk);
		sys_en = 1'b0;
		r0 = n_rise;
		strobe(0);
		tick(30);
		check("busy off", {15'h0000, busy}, 16'h0000);
		check("sck oe off", {15'h0000, o_sck_oe}, 16'h0000);
		check("no clock", 16'(n_rise - r0), 16'h0000);
		sys_en = 1'b1;
		tick(2);
	endtask
	task automatic t_nofault();
		for (int k = 0; k < 2; k++) begin
			@(negedge clk);
			{mst, soe, fden, swire} = (k == 0) ? 4'h8 : 4'h2;
			ss_pull = 1'b1;
			tick(10);
			check("fault clear", {15'h0000, flt}, 16'h0000);
			check("sck role", {15'h0000, o_sck_oe}, {15'h0000, mst});
			ss_pull = 1'b0;
			tick(8);
		end
	endtask
	task automatic t_fault();
		@(negedge clk);
		{mst, soe, fden, swire, shoe} = 5'h17;
		prs = 3'h0;
		rte = 4'h8;
		strobe(0);
		tick(10);
		check("shared oe", {15'h0000, o_mosi_oe}, 16'h0001);
		check("miso unused", {15'h0000, o_miso_oe}, 16'h0000);
		ss_pull = 1'b1;
		tick(8);
		check("fault set", {15'h0000, flt}, 16'h0001);
		check("aborted", {15'h0000, busy}, 16'h0000);
		check("demoted", {15'h0000, mact}, 16'h0000);
		check("sck released", {15'h0000, o_sck_oe}, 16'h0000);
		check("shared off", {15'h0000, o_mosi_oe}, 16'h0000);
		irqen = 1'b1;
		tick(2);
		check("fault irq", {15'h0000, irq}, 16'h0001);
		ss_pull = 1'b0;
		tick(8);
		strobe(2);
		strobe(3);
		tick(2);
		check("fault cleared", {15'h0000, flt}, 16'h0000);
		check("master again", {15'h0000, mact}, 16'h0001);
		check("shared blocked", {15'h0000, o_mosi_oe}, 16'h0000);
		{irqen, shoe} = 2'h0;
	endtask
	// Bench acts as master on the pins; lp enters wait mid-byte
	task automatic t_slave(input logic [7:0] ws, input logic [7:0] rb, input logic lp);
		logic [7:0] got;
		got = 8'h00;
		@(negedge clk);
		{mst, soe, fden, swire} = 4'h0;
		wdata = ws;
		strobe(0);
		ss_pull = 1'b1;
		tick(10);
		for (int i = 0; i < 8; i++) begin
			bmosi = rb[7 - i];
			if (lp && i == 3) begin
				{wt, siw} = 2'h3;
			end
			tick(8);
			got = {got[6:0], miso_w};
			bsck = 1'b1;
			tick(8);
			bsck = 1'b0;
		end
		tick(8);
		if (lp) begin
			check("rx deferred", {15'h0000, rxf}, 16'h0000);
			{wt, siw} = 2'h0;
			tick(3);
		end
		check("slave tx", {8'h00, got}, {8'h00, ws});
		check("slave rx", {8'h00, dreg}, {8'h00, rb});
		check("slave flag", {15'h0000, rxf}, 16'h0001);
		ss_pull = 1'b0;
		bmosi = 1'b1;
		tick(8);
	endtask
	initial begin
		{sys_en, mst, soe, fden, swire, shoe, siw, irqen} = 8'h80;
		{wt, stp, dstop, dwr, drd, srd, cwr, ss_pull} = 8'h00;
		prs = 3'h0;
		rte = 4'h0;
		wdata = 8'h00;
		ptx = 8'h00;
		tick(8);
		rst_n = 1'b1;
		tick(8);
		check("data reset", {8'h00, dreg}, 16'h0000);
		check("ss reset", {15'h0000, o_ss_n}, 16'h0001);
		check("idle sck", 16'(n_rise), 16'h0000);
		xfer(3'h2, 4'h1, 8'hA5, 8'h3C, 0);
		irqen = 1'b1;
		tick(3);
		check("irq on", {15'h0000, irq}, 16'h0001);
		strobe(1);
		tick(2);
		check("irq off", {15'h0000, irq}, 16'h0000);
		irqen = 1'b0;
		xfer(3'h7, 4'h0, 8'h81, 8'h7E, 1);
		strobe(1);
		xfer(3'h2, 4'h2, 8'h96, 8'h69, 2);
		strobe(1);
		xfer(3'h0, 4'h8, 8'h5A, 8'hC3, 0);
		@(negedge clk);
		dstop = 1'b1;
		@(negedge clk);
		dstop = 1'b0;
		tick(2);
		check("deep rx", {15'h0000, rxf}, 16'h0000);
		check("deep data", {8'h00, dreg}, 16'h0000);
		t_disable();
		t_nofault();
		t_fault();
		t_slave(8'hC9, 8'h35, 1'b0);
		strobe(1);
		t_slave(8'h2E, 8'hB4, 1'b1);
		strobe(1);
		end_sim();
	end
endmodule
